// ### rtl/acc_regs.vh
// Purpose: Constants for the converter control block
// Assumes: 8-bit register port, 10 MHz system clock
// Notes: Offsets are local register indices
//
// Notes on behaviour
// R01: Start bit written high then low launches exactly one conversion.
// R02: Start bit held high keeps the converter in reset, busy reads one.
// R03: Busy flag, primary bit 6, is read only and shows a running conversion.
// R04: Busy flag clears by hardware when the conversion completes.
// R05: Completion raises the interrupt request flag; enabled requests go out.
// R06: Power bit 5: zero powers the converter, one powers it down; resets one.
// R07: Software should power down before idle or sleep modes.
// R08: Format bit selects left or right aligned result; unused bits zero.
// R09: Channel field routes input 0, a floating input, inputs 2 to 8.
// R10: Bandgap select routes the 1.25V bandgap, disconnecting external inputs.
// R11: Software enables the bandgap before selecting the bandgap channel.
// R12: Bandgap powers off when unused by converter and low-voltage functions.
// R13: Software waits for bandgap settling before converting on it.
// R14: Reference bit 4 picks supply at zero, external reference pin at one.
// R15: Clock field divides system clock by 1 to 64; code 111 undefined.
// R16: Software keeps the conversion clock period between 0.53 and 10 us.
// R17: Secondary bits 5 and 3 ignore writes and read zero.
// R18: A pin used as converter input loses digital function and pull-high.
// R19: With interrupt disabled, software polls busy until it reads zero.
// R20: A conversion takes sixteen conversion clock periods.
// R21: Software waits a power-up delay after clearing power down.
// R22: Start bit should be zero before the launch sequence.
// R23: Both result bytes update together in the cycle busy clears.
// R24: While powered down, starts are ignored and busy and results hold.
`ifndef ACC_REGS_VH
`define ACC_REGS_VH
`define ACC_OFF_RESULT_HIGH 2'h0
`define ACC_OFF_RESULT_LOW 2'h1
`define ACC_OFF_CTRL_PRI 2'h2
`define ACC_OFF_CTRL_SEC 2'h3
`define ACC_PRI_START 7
`define ACC_PRI_BUSY 6
`define ACC_PRI_PDOWN 5
`define ACC_PRI_ALIGN 4
`define ACC_SEC_BGSEL 7
`define ACC_SEC_BGEN 6
`define ACC_SEC_REFSEL 4
`define ACC_SEC_WMASK 8'hD7
`define ACC_RST_CTRL_PRI 8'h60
`define ACC_RST_CTRL_SEC 8'h00
`define ACC_CONV_PERIODS 5'h10
`define ACC_DIV_UNDEF 3'h7
`endif

// ### rtl/acc_clkdiv.v
// Purpose: Conversion clock tick generator from the system clock
// Assumes: Divider code steady while a conversion runs
// Notes: Tick is one system cycle wide, period 2^code cycles, 64 cycles for code 7
`timescale 1ns/10ps
`include "acc_regs.vh"
module acc_clkdiv (
    input wire clk,
    input wire rst,
    input wire run,
    input wire [2:0] div_code,
    output reg tick_q
);
    reg [5:0] cnt_q;
    reg [5:0] cnt_d;
    reg [5:0] limit;
    always @* begin
        // Undefined code behaves as the slowest ratio
        if (div_code == `ACC_DIV_UNDEF) begin
            limit = 6'h3F; // see R15
        end else begin
            limit = (6'h01 << div_code) - 6'h01; // see R15
        end
        cnt_d = cnt_q + 6'h01;
        if (!run || cnt_q >= limit) begin
            cnt_d = 6'h00;
        end
    end
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 6'h00;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= run && (cnt_q >= limit);
        end
    end
endmodule // acc_clkdiv

// ### rtl/acc_ctrl.v
// Purpose: Control, status and result registers of the 12-bit converter
// Assumes: Analog core presents its 12-bit value on core_result at the end
// Notes: Register port reads answer one cycle after the read strobe
`timescale 1ns/10ps
`include "acc_regs.vh"
module acc_ctrl (
    input wire clk,
    input wire rst,
    input wire [1:0] addr,
    input wire [7:0] wdata,
    input wire wr_en,
    input wire rd_en,
    output reg [7:0] rdata_q,
    input wire [11:0] core_result,
    input wire lv_functions_on,
    input wire [8:0] pin_analog_sel,
    output reg core_reset_q,
    output reg core_power_q,
    output reg core_sample_q,
    output reg core_done_q,
    output reg [8:0] chan_onehot_q,
    output reg bandgap_route_q,
    output reg bandgap_power_q,
    output reg ref_external_q,
    output reg [8:0] pin_digital_off_q,
    output reg irq_flag_q,
    output reg irq_q,
    input wire irq_enable,
    input wire irq_flag_clr
);
    ////////////////////////////////////////////////////////////////
    // Registers
    reg start_q;
    reg busy_q;
    reg pdown_q;
    reg align_q;
    reg [3:0] chan_q;
    reg [7:0] sec_q;
    reg [7:0] res_hi_q;
    reg [7:0] res_lo_q;
    reg running_q;
    reg [4:0] period_q;
    wire tick;
    wire wr_pri;
    wire start_fall;
    wire finish;
    wire done_now;
    wire [7:0] hi_d;
    wire [7:0] lo_d;

    // Channel code to one-hot input select, code 1 and above 8 floating
    function [8:0] chan_decode;
        input [3:0] code;
        begin
            chan_decode = 9'h000;
            if (code <= 4'h8 && code != 4'h1) begin
                chan_decode = 9'h001 << code; // see R09
            end
        end
    endfunction

    assign wr_pri = wr_en && (addr == `ACC_OFF_CTRL_PRI);
    // Launch on the write that takes start from one to zero
    assign start_fall = wr_pri && start_q && !wdata[`ACC_PRI_START]; // see R01
    assign finish = running_q && tick && (period_q == `ACC_CONV_PERIODS - 5'h01);
    // Completion counts only when not powered down or restarted in the same cycle
    assign done_now = finish && !pdown_q && !(wr_pri && wdata[`ACC_PRI_START]);
    assign hi_d = align_q ? {4'h0, core_result[11:8]} : core_result[11:4]; // see R08
    assign lo_d = align_q ? core_result[7:0] : {core_result[3:0], 4'h0}; // see R08

    acc_clkdiv u_div (
        .clk(clk),
        .rst(rst),
        .run(running_q),
        .div_code(sec_q[2:0]),
        .tick_q(tick)
    );

    ////////////////////////////////////////////////////////////////
    // Control state and conversion sequencing
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            start_q <= 1'b0;
            busy_q <= 1'b1;
            pdown_q <= 1'b1; // see R06
            align_q <= 1'b0;
            chan_q <= 4'h0;
            sec_q <= `ACC_RST_CTRL_SEC;
            res_hi_q <= 8'h00;
            res_lo_q <= 8'h00;
            running_q <= 1'b0;
            period_q <= 5'h00;
        end else begin
            if (wr_pri) begin
                start_q <= wdata[`ACC_PRI_START];
                pdown_q <= wdata[`ACC_PRI_PDOWN];
                align_q <= wdata[`ACC_PRI_ALIGN];
                chan_q <= wdata[3:0];
            end
            if (wr_en && addr == `ACC_OFF_CTRL_SEC) begin
                sec_q <= wdata & `ACC_SEC_WMASK; // see R17
            end
            if (pdown_q) begin
                // Powered down: hold busy and results
                running_q <= 1'b0; // see R24
                period_q <= 5'h00;
            end else if (wr_pri && wdata[`ACC_PRI_START]) begin
                running_q <= 1'b0; // see R02
                period_q <= 5'h00;
                busy_q <= 1'b1; // see R02
            end else if (start_fall) begin
                running_q <= 1'b1; // see R01
                period_q <= 5'h00;
                busy_q <= 1'b1; // see R03
            end else if (running_q && tick) begin
                period_q <= period_q + 5'h01; // see R20
                if (finish) begin
                    running_q <= 1'b0;
                    busy_q <= 1'b0; // see R04
                    res_hi_q <= hi_d; // see R23
                    res_lo_q <= lo_d; // see R23
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Interrupt request flag, set wins over clear
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_flag_q <= 1'b0;
            irq_q <= 1'b0;
            core_done_q <= 1'b0;
        end else begin
            core_done_q <= done_now;
            if (done_now) begin
                irq_flag_q <= 1'b1; // see R05
            end else if (irq_flag_clr) begin
                irq_flag_q <= 1'b0;
            end
            irq_q <= irq_enable && (irq_flag_q || done_now); // see R05
        end
    end

    ////////////////////////////////////////////////////////////////
    // Analog core and pin controls
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            core_reset_q <= 1'b1;
            core_power_q <= 1'b0;
            core_sample_q <= 1'b0;
            chan_onehot_q <= 9'h000;
            bandgap_route_q <= 1'b0;
            bandgap_power_q <= 1'b0;
            ref_external_q <= 1'b0;
            pin_digital_off_q <= 9'h000;
        end else begin
            core_reset_q <= start_q || pdown_q; // see R02
            core_power_q <= !pdown_q; // see R06
            core_sample_q <= running_q && !pdown_q;
            if (sec_q[`ACC_SEC_BGSEL]) begin
                chan_onehot_q <= 9'h000; // see R10
            end else begin
                chan_onehot_q <= chan_decode(chan_q); // see R09
            end
            bandgap_route_q <= sec_q[`ACC_SEC_BGSEL]; // see R10
            bandgap_power_q <= lv_functions_on ||
                (sec_q[`ACC_SEC_BGEN] && sec_q[`ACC_SEC_BGSEL]); // see R12
            ref_external_q <= sec_q[`ACC_SEC_REFSEL]; // see R14
            pin_digital_off_q <= pin_analog_sel; // see R18
        end
    end

    ////////////////////////////////////////////////////////////////
    // Register read port
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (rd_en) begin
            case (addr)
                `ACC_OFF_RESULT_HIGH: rdata_q <= res_hi_q;
                `ACC_OFF_RESULT_LOW: rdata_q <= res_lo_q;
                `ACC_OFF_CTRL_PRI: rdata_q <= {start_q, busy_q, pdown_q, align_q, chan_q}; // see R03
                `ACC_OFF_CTRL_SEC: rdata_q <= sec_q;
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
endmodule // acc_ctrl

// ### sim/acc_ctrl_properties.sv
// Purpose: Port checker for the converter control block
// Assumes: Bound to acc_ctrl, one clock domain
// Notes: Watches design inputs and outputs
`timescale 1ns/10ps
module acc_ctrl_chk (
    input wire clk, input wire rst, input wire [1:0] addr, input wire rd_en,
    input wire [7:0] rdata_q, input wire core_reset_q, input wire core_power_q,
    input wire core_sample_q, input wire core_done_q, input wire [8:0] chan_onehot_q,
    input wire bandgap_route_q, input wire irq_flag_q, input wire irq_q, input wire irq_enable,
    input wire [8:0] pin_analog_sel, input wire [8:0] pin_digital_off_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_rd_ctrl;
        rd_en && addr == 2'h2;
    endsequence
    chk_rd_idle: assert property (!$past(rd_en) |-> rdata_q == 8'h00)
        else $error("read data outside read");
    chk_rd_busy: assert property (s_rd_ctrl ##1 core_sample_q |-> rdata_q[6])
        else $error("busy low while converting");
    chk_rst_idle: assert property (core_reset_q |-> !core_sample_q)
        else $error("converting in reset");
    chk_run_pwr: assert property (core_sample_q |-> core_power_q)
        else $error("converting powered down");
    chk_done_once: assert property (core_done_q |=> !core_done_q)
        else $error("done pulse too long");
    chk_done_flag: assert property (core_done_q |-> irq_flag_q)
        else $error("done without request flag");
    chk_irq_gate: assert property (irq_q |-> $past(irq_enable))
        else $error("interrupt while disabled");
    chk_chan_sel: assert property ($onehot0(chan_onehot_q) && !chan_onehot_q[1])
        else $error("bad channel select");
    chk_bg_excl: assert property (bandgap_route_q |-> chan_onehot_q == 9'h000)
        else $error("external input with bandgap");
    chk_pin_copy: assert property (!$past(rst) |-> pin_digital_off_q == $past(pin_analog_sel))
        else $error("pin function not removed");
endmodule // acc_ctrl_chk
////////////////////////////////////////////////////////////////////////////////
bind acc_ctrl acc_ctrl_chk chk (.clk(clk), .rst(rst), .addr(addr), .rd_en(rd_en),
    .rdata_q(rdata_q), .core_reset_q(core_reset_q), .core_power_q(core_power_q),
    .core_sample_q(core_sample_q), .core_done_q(core_done_q), .chan_onehot_q(chan_onehot_q),
    .bandgap_route_q(bandgap_route_q), .irq_flag_q(irq_flag_q), .irq_q(irq_q),
    .irq_enable(irq_enable), .pin_analog_sel(pin_analog_sel),
    .pin_digital_off_q(pin_digital_off_q));

// ### sim/acc_core_model.sv
// Purpose: Analog core stand-in
// Assumes: Value only meaningful while sampling
// Notes: Inverted value outside a conversion
`timescale 1ns/10ps
module acc_core_model (
    input wire sampling,
    input wire [11:0] value,
    output wire [11:0] result
);
    assign result = sampling ? value : ~value;
endmodule // acc_core_model

// ### sim/tb.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: 10 MHz clock, register port reads answer next cycle
// Notes: Table rows per conversion, hand tests after
`timescale 1ns/10ps
module tb;
    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] pri;
        logic [11:0] val;
        logic [15:0] res;
        logic [8:0] ch;
    } acc_row_t;
    acc_row_t rows [5] = '{'{8'h00, 8'h00, 12'hABC, 16'hABC0, 9'h001},
        '{8'h01, 8'h12, 12'h5A3, 16'h05A3, 9'h004}, '{8'h12, 8'h08, 12'hFFF, 16'hFFF0, 9'h100},
        '{8'hC6, 8'h11, 12'h001, 16'h0001, 9'h000}, '{8'h07, 8'h01, 12'h800, 16'h8000, 9'h000}};
    logic clk = 1'h0, rst = 1'h1, wr_en = 1'h0, rd_en = 1'h0, lv_on = 1'h0, irq_en = 1'h0;
    logic flag_clr = 1'h0, c_rst, c_pwr, c_smp, c_done, bg_route, bg_pwr, ref_ext, irq_flag_q, irq_q;
    logic [1:0] addr = 2'h0;
    logic [7:0] wdata = 8'h00, rdata_q, rv;
    logic [11:0] core_val = 12'h000, core_result;
    logic [8:0] pin_sel = 9'h000, chan_q, pin_off_q;
    int fails = 0, total_checks = 0, n, d;
    acc_ctrl uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
        .rdata_q(rdata_q), .core_result(core_result), .lv_functions_on(lv_on),
        .pin_analog_sel(pin_sel), .core_reset_q(c_rst), .core_power_q(c_pwr),
        .core_sample_q(c_smp), .core_done_q(c_done), .chan_onehot_q(chan_q),
        .bandgap_route_q(bg_route), .bandgap_power_q(bg_pwr), .ref_external_q(ref_ext),
        .pin_digital_off_q(pin_off_q), .irq_flag_q(irq_flag_q), .irq_q(irq_q),
        .irq_enable(irq_en), .irq_flag_clr(flag_clr));
    acc_core_model core (.sampling(c_smp), .value(core_val), .result(core_result));
    initial forever #50 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_en <= 1'h1;
        @(posedge clk);
        wr_en <= 1'h0;
    endtask
    task automatic rd(input logic [1:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'h1;
        @(posedge clk);
        rd_en <= 1'h0;
        @(negedge clk);
        rv = rdata_q;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #(100 * 20000);
        fails++;
        print_verdict;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        rd(2'h2);
        chk("primary reset", rv, 8'h60);
        rd(2'h3);
        chk("secondary reset", rv, 8'h00);
        wr(2'h0, 8'h55);
        wr(2'h2, 8'hA0);
        wr(2'h2, 8'h20);
        repeat (40) @(posedge clk);
        rd(2'h2);
        chk("start while down", rv, 8'h60);
        chk("core held reset", c_rst, 1'h1);
        chk("core unpowered", c_pwr, 1'h0);
        rd(2'h0);
        chk("result held", rv, 8'h00);
        $display("reset test done");
        foreach (rows[i]) begin
            @(posedge clk);
            irq_en <= i[0];
            pin_sel <= 9'h001 << i;
            core_val <= rows[i].val;
            d = 1 << ((rows[i].sec[2:0] == 3'h7) ? 6 : rows[i].sec[2:0]);
            wr(2'h3, rows[i].sec & 8'h7F);
            wr(2'h3, rows[i].sec);
            repeat (8) @(posedge clk);
            wr(2'h2, rows[i].pri);
            repeat (4) @(posedge clk);
            wr(2'h2, rows[i].pri | 8'h80);
            rd(2'h2);
            chk("busy on start", rv, rows[i].pri | 8'hC0);
            chk("core reset", c_rst, 1'h1);
            chk("core powered", c_pwr, 1'h1);
            wr(2'h2, rows[i].pri);
            n = 0;
            rd(2'h2);
            while (rv[6] === 1'h1 && n < 3000) begin
                rd(2'h2);
                n++;
            end
            chk("conversion time", n >= 8 * d - 1 && n <= 8 * d + 2, 1'h1);
            chk("busy cleared", rv, rows[i].pri);
            chk("request flag", irq_flag_q, 1'h1);
            chk("interrupt out", irq_q, i[0]);
            rd(2'h0);
            chk("result high", rv, rows[i].res[15:8]);
            rd(2'h1);
            chk("result low", rv, rows[i].res[7:0]);
            chk("channel", chan_q, rows[i].ch);
            chk("reference", ref_ext, rows[i].sec[4]);
            chk("bandgap power", bg_pwr, rows[i].sec[7] & rows[i].sec[6]);
            chk("pin function", pin_off_q, 9'h001 << i);
            chk("bandgap route", bg_route, rows[i].sec[7]);
            @(posedge clk);
            flag_clr <= 1'h1;
            @(posedge clk);
            flag_clr <= 1'h0;
            @(negedge clk);
            chk("flag clear", irq_flag_q, 1'h0);
            $display("row %0d done", i);
        end
        wr(2'h2, 8'h40);
        rd(2'h2);
        chk("busy write", rv, 8'h00);
        wr(2'h3, 8'h28);
        lv_on <= 1'h1;
        rd(2'h3);
        chk("unused bits", rv, 8'h00);
        rd(2'h3);
        chk("bandgap by lv", bg_pwr, 1'h1);
        wr(2'h2, 8'h20);
        rd(2'h2);
        chk("power down", rv, 8'h20);
        chk("core power off", c_pwr, 1'h0);
        $display("hand tests done");
        wr(2'h2, 8'h00);
        repeat (4) @(posedge clk);
        wr(2'h3, 8'h03);
        wr(2'h2, 8'h80);
        wr(2'h2, 8'h00);
        repeat (20) @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        rd(2'h2);
        chk("primary after reset", rv, 8'h60);
        chk("core reset after reset", c_rst, 1'h1);
        rd(2'h0);
        chk("result after reset", rv, 8'h00);
        $display("mid-run reset test done");
        print_verdict;
    end
endmodule // tb
